// ---- hw/etp_tx_payload.sv ----
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Serial master mode times all transmit work from the reference clock.
// - Serial mode samples one payload bit per reference clock rising edge.
// - Serial mode starts frames on its own timing, no external frame input.
// - Frame-boundary output high exactly one bit period, during last frame bit.
// - Overhead indicator high one bit period before each overhead bit.
// - Serial master mode when nibble select low and timing select is 01.
// - Nibble mode times from receive line clock, drives it divided by four.
// - Nibble mode accepts four-bit nibbles latched per nibble clock rise.
// - Nibble frame-boundary high one nibble period on last frame nibble.
// - Nibble value taken on third recovered clock rise after nibble clock.
// - Exactly 1074 nibble clock pulses between consecutive nibble frame pulses.
// - One nibble clock pulse per four reference periods, payload pulses spread.
// - Nibble overhead indicator 14 nibbles per frame, first four at start.
// - Five further two-nibble overhead pulses over the rest of the frame.
// - Nibble loop mode when nibble select high and timing select is 00.
module etp_tx_payload (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire etp_pkg::etp_apb_req_s APB_REQ_IN,
    output etp_pkg::etp_apb_rsp_s APB_RSP_OUT,
    input wire logic TX_REFERENCE_CLOCK_IN,
    input wire logic RECEIVE_LINE_CLOCK_IN,
    input wire logic RECOVERED_RECEIVE_CLOCK_IN,
    input wire logic SERIAL_PAYLOAD_IN,
    input wire logic [3:0] NIBBLE_PAYLOAD_IN,
    input wire logic NIBBLE_SELECT_IN,
    output logic FRAME_BOUNDARY_OUT,
    output logic OVERHEAD_INDICATOR_OUT,
    output logic NIBBLE_CLOCK_OUT,
    output logic NIBBLE_FRAME_BOUNDARY_OUT,
    output logic NIBBLE_OVERHEAD_INDICATOR_OUT,
    output etp_pkg::etp_payload_s PAYLOAD_OUT
);
    import etp_pkg::*;

    // True when a frame byte index is an overhead byte
    function automatic logic is_oh_byte(input logic [9:0] b);
        is_oh_byte = (b < FA_BYTES) || ((b % OH_STRIDE) == 10'h000 && b <= OH_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, filtered level moves when stages 2 and 3 agree

    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] next_pin_lvl;
    logic [PIN_W-1:0] pin_rise;

    assign pins = {NIBBLE_PAYLOAD_IN, NIBBLE_SELECT_IN, SERIAL_PAYLOAD_IN, RECOVERED_RECEIVE_CLOCK_IN,
                   RECEIVE_LINE_CLOCK_IN, TX_REFERENCE_CLOCK_IN};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] stage;
            logic [SYNC_STAGES-1:0] next_stage;
            // Shift the pin through the chain
            always_comb begin
                next_stage = {stage[SYNC_STAGES-2:0], pins[gi]};
            end
            always_ff @(posedge MCLK_IN) begin
                if (RST_IN) begin
                    stage <= SYNC_RESET;
                end else begin
                    stage <= next_stage;
                end
            end
            // Filtered level follows only agreeing later stages
            always_comb begin
                next_pin_lvl[gi] = (stage[1] == stage[2]) ? stage[2] : pin_lvl[gi];
                pin_rise[gi] = next_pin_lvl[gi] & ~pin_lvl[gi];
            end
        end
    endgenerate

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            pin_lvl <= '0;
        end else begin
            pin_lvl <= next_pin_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB register file

    logic [7:0] opmode;
    logic [7:0] next_opmode;
    logic [15:0] frame_count;
    logic [15:0] next_frame_count;
    logic [1:0] trs;
    logic apb_access;
    logic addr_ok;
    etp_mode_e mode;
    logic [12:0] bit_cnt;
    logic [10:0] nib_idx;

    assign trs = opmode[TRS_LSB +: 2];
    assign apb_access = APB_REQ_IN.psel & APB_REQ_IN.penable;
    assign addr_ok = (APB_REQ_IN.paddr == OPMODE_ADDR) || (APB_REQ_IN.paddr == STATUS_ADDR) ||
                     (APB_REQ_IN.paddr == POSITION_ADDR);

    // Zero-wait slave, unmapped addresses answer with an error
    always_comb begin
        APB_RSP_OUT.pready = 1'b1;
        APB_RSP_OUT.pslverr = apb_access & ~addr_ok;
        APB_RSP_OUT.prdata = 32'h0000_0000;
        case (APB_REQ_IN.paddr)
            OPMODE_ADDR: begin
                APB_RSP_OUT.prdata[7:0] = opmode;
            end
            STATUS_ADDR: begin
                APB_RSP_OUT.prdata[STAT_MODE_LSB +: 2] = mode;
                APB_RSP_OUT.prdata[STAT_FRAMES_LSB +: 16] = frame_count;
            end
            POSITION_ADDR: begin
                APB_RSP_OUT.prdata[POS_BIT_LSB +: 13] = bit_cnt;
                APB_RSP_OUT.prdata[POS_NIB_LSB +: 11] = nib_idx;
            end
            default: begin
                APB_RSP_OUT.prdata = 32'h0000_0000;
            end
        endcase
    end

    // Operating mode register write
    always_comb begin
        next_opmode = opmode;
        if (apb_access && APB_REQ_IN.pwrite && APB_REQ_IN.paddr == OPMODE_ADDR) begin
            next_opmode = APB_REQ_IN.pwdata[7:0];
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            opmode <= OPMODE_RESET;
        end else begin
            opmode <= next_opmode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode selection

    etp_mode_e next_mode;
    always_comb begin
        next_mode = ETP_IDLE;
        if (!pin_lvl[PIN_NSEL] && trs == TRS_LOCAL) begin
            next_mode = ETP_SERIAL;
        end else if (pin_lvl[PIN_NSEL] && trs == TRS_LOOP) begin
            next_mode = ETP_NIBBLE;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            mode <= ETP_IDLE;
        end else begin
            mode <= next_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame timing: serial bit counter and nibble divider, index and sampler

    logic ref_edge;
    logic [12:0] next_bit_cnt;
    logic [1:0] div;
    logic [1:0] next_div;
    logic [10:0] next_nib_idx;
    logic armed;
    logic next_armed;
    logic [1:0] samp_cnt;
    logic [1:0] next_samp_cnt;
    logic samp_oh;
    logic next_samp_oh;
    logic nib_rise;
    logic [12:0] bit_after;
    etp_payload_s next_payload;

    assign bit_after = (bit_cnt == FRAME_BIT_LAST) ? 13'h0000 : bit_cnt + 13'h0001;

    // Serial mode runs on the transmit reference clock, nibble mode on the line clock
    always_comb begin
        case (mode)
            ETP_SERIAL: ref_edge = pin_rise[PIN_TXCLK];
            ETP_NIBBLE: ref_edge = pin_rise[PIN_RXCLK];
            default: ref_edge = 1'b0;
        endcase
    end

    // One nibble clock rise for every four reference periods
    assign nib_rise = (mode == ETP_NIBBLE) && ref_edge && div == NIB_DIV_LAST;

    always_comb begin
        next_bit_cnt = bit_cnt;
        next_div = div;
        next_nib_idx = nib_idx;
        next_armed = armed;
        next_samp_cnt = samp_cnt;
        next_samp_oh = samp_oh;
        next_frame_count = frame_count;
        next_payload = '0;
        case (mode)
            ETP_SERIAL: begin
                if (ref_edge) begin
                    // Free-running frame timing, no external frame reference
                    next_bit_cnt = bit_after;
                    if (bit_cnt == FRAME_BIT_LAST) begin
                        next_frame_count = frame_count + 16'h0001;
                    end
                    if (!is_oh_byte(bit_cnt[12:3])) begin
                        next_payload.valid = 1'b1;
                        next_payload.data = {3'h0, pin_lvl[PIN_SER]};
                    end
                end
            end
            ETP_NIBBLE: begin
                if (ref_edge) begin
                    next_div = div + 2'h1;
                end
                if (nib_rise) begin
                    // Index wraps after the 1074th nibble
                    next_nib_idx = (nib_idx == FRAME_NIB_LAST) ? 11'h000 : nib_idx + 11'h001;
                    if (nib_idx == FRAME_NIB_LAST) begin
                        next_frame_count = frame_count + 16'h0001;
                    end
                    next_armed = 1'b1;
                    next_samp_cnt = 2'h0;
                    next_samp_oh = is_oh_byte(next_nib_idx[10:1]);
                end else if (armed && pin_rise[PIN_RECCLK]) begin
                    next_samp_cnt = samp_cnt + 2'h1;
                    if (samp_cnt + 2'h1 == SAMPLE_EDGE) begin
                        // Third recovered edge after the nibble clock rise
                        next_armed = 1'b0;
                        next_payload.valid = ~samp_oh;
                        next_payload.nibble = 1'b1;
                        next_payload.data = pin_lvl[PIN_NIB +: 4];
                    end
                end
            end
            default: begin
                next_bit_cnt = 13'h0000;
                next_div = 2'h0;
                next_nib_idx = 11'h000;
                next_armed = 1'b0;
                next_samp_cnt = 2'h0;
                next_samp_oh = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            bit_cnt <= 13'h0000;
            div <= 2'h0;
            nib_idx <= 11'h000;
            armed <= 1'b0;
            samp_cnt <= 2'h0;
            samp_oh <= 1'b0;
            frame_count <= 16'h0000;
            PAYLOAD_OUT <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
            div <= next_div;
            nib_idx <= next_nib_idx;
            armed <= next_armed;
            samp_cnt <= next_samp_cnt;
            samp_oh <= next_samp_oh;
            frame_count <= next_frame_count;
            PAYLOAD_OUT <= next_payload;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Terminal strobes, decoded from counters and gated by mode

    always_comb begin
        FRAME_BOUNDARY_OUT = (mode == ETP_SERIAL) && bit_cnt == FRAME_BIT_LAST;
        OVERHEAD_INDICATOR_OUT = (mode == ETP_SERIAL) && is_oh_byte(bit_after[12:3]);
        NIBBLE_CLOCK_OUT = (mode == ETP_NIBBLE) && div < NIB_HIGH_END;
        NIBBLE_FRAME_BOUNDARY_OUT = (mode == ETP_NIBBLE) && nib_idx == FRAME_NIB_LAST;
        NIBBLE_OVERHEAD_INDICATOR_OUT = (mode == ETP_NIBBLE) && is_oh_byte(nib_idx[10:1]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    logic [10:0] chk_nibs;
    logic [3:0] chk_oh_nibs;
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN || mode != ETP_NIBBLE) begin
            chk_nibs <= 11'h000;
            chk_oh_nibs <= 4'h0;
        end else if (nib_rise) begin
            chk_nibs <= (nib_idx == FRAME_NIB_LAST) ? 11'h000 : chk_nibs + 11'h001;
            chk_oh_nibs <= (nib_idx == FRAME_NIB_LAST) ? 4'h0 : chk_oh_nibs + {3'h0, NIBBLE_OVERHEAD_INDICATOR_OUT};
        end
    end

    chk_serial_mode_sel: assert property ((!pin_lvl[PIN_NSEL] && trs == 2'h1) |=> mode == ETP_SERIAL)
        else $error("serial mode not selected");
    chk_nibble_mode_sel: assert property ((pin_lvl[PIN_NSEL] && trs == 2'h0) |=> mode == ETP_NIBBLE)
        else $error("nibble mode not selected");
    chk_frame_one_bit: assert property ($rose(FRAME_BOUNDARY_OUT) |-> $past(bit_cnt) == 13'h10c6)
        else $error("frame boundary not on last bit");
    chk_serial_sample: assert property ((mode == ETP_SERIAL && ref_edge && bit_cnt == 13'h0010 &&
        next_mode == ETP_SERIAL) |=> PAYLOAD_OUT.valid && PAYLOAD_OUT.data[0] == $past(pin_lvl[PIN_SER]))
        else $error("serial payload bit not sampled");
    chk_oh_ahead: assert property ((mode == ETP_SERIAL && bit_cnt == 13'h000f && ref_edge && next_mode == mode)
        |=> !OVERHEAD_INDICATOR_OUT)
        else $error("overhead indicator late");
    chk_nib_frame_count: assert property ($rose(NIBBLE_FRAME_BOUNDARY_OUT) |-> chk_nibs == 11'h431)
        else $error("nibble count per frame wrong");
    chk_nib_oh_total: assert property ((nib_rise && nib_idx == FRAME_NIB_LAST) |-> chk_oh_nibs == 4'he)
        else $error("overhead nibble total wrong");
    chk_nib_fa_start: assert property ((mode == ETP_NIBBLE && nib_idx < 11'h004) |-> NIBBLE_OVERHEAD_INDICATOR_OUT)
        else $error("frame start overhead missing");
    chk_nib_latch_third: assert property ((armed && samp_cnt == 2'h2 && pin_rise[PIN_RECCLK] && !nib_rise &&
        mode == ETP_NIBBLE) |=> PAYLOAD_OUT.nibble && !armed)
        else $error("nibble not taken on third edge");
    chk_nib_div_four: assert property (nib_rise |-> div == 2'h3 && NIBBLE_CLOCK_OUT == 1'b0)
        else $error("nibble clock divide wrong");
    chk_idle_low: assert property ((mode == ETP_IDLE) |-> !FRAME_BOUNDARY_OUT && !OVERHEAD_INDICATOR_OUT &&
        !NIBBLE_FRAME_BOUNDARY_OUT && !NIBBLE_OVERHEAD_INDICATOR_OUT && !NIBBLE_CLOCK_OUT)
        else $error("strobe active while idle");
endmodule

// ---- hw/etp_pkg.sv ----
package etp_pkg;
    // Register map
    localparam logic [7:0] OPMODE_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] POSITION_ADDR = 8'h08;
    localparam logic [7:0] OPMODE_RESET = 8'h28;
    localparam int TRS_LSB = 0;
    localparam logic [1:0] TRS_LOCAL = 2'h1;
    localparam logic [1:0] TRS_LOOP = 2'h0;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_FRAMES_LSB = 16;
    localparam int POS_BIT_LSB = 0;
    localparam int POS_NIB_LSB = 16;

    // Frame geometry: 537 bytes, 4296 bits, 1074 nibbles
    localparam logic [12:0] FRAME_BIT_LAST = 13'h10c7;
    localparam logic [10:0] FRAME_NIB_LAST = 11'h431;
    localparam logic [9:0] FA_BYTES = 10'h002;
    localparam logic [9:0] OH_STRIDE = 10'h059;
    localparam logic [9:0] OH_LAST = 10'h1bd;

    // Nibble clock divider and sampling delay
    localparam logic [1:0] NIB_DIV_LAST = 2'h3;
    localparam logic [1:0] NIB_HIGH_END = 2'h2;
    localparam logic [1:0] SAMPLE_EDGE = 2'h3;

    // Pin vector layout and synchroniser depth
    localparam int PIN_TXCLK = 0;
    localparam int PIN_RXCLK = 1;
    localparam int PIN_RECCLK = 2;
    localparam int PIN_SER = 3;
    localparam int PIN_NSEL = 4;
    localparam int PIN_NIB = 5;
    localparam int PIN_W = 9;
    localparam int SYNC_STAGES = 3;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {
        ETP_IDLE = 2'b00,
        ETP_SERIAL = 2'b01,
        ETP_NIBBLE = 2'b10
    } etp_mode_e;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } etp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } etp_apb_rsp_s;

    typedef struct packed {
        logic valid;
        logic nibble;
        logic [3:0] data;
    } etp_payload_s;
endpackage

// ---- tb/etp_term_model.sv ----
`timescale 1ns/1ps
// Terminal side: shared line clock, serial and nibble payload source
module etp_term_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] half_in,
    input wire logic [31:0] rnd_in,
    input wire logic oh_in,
    input wire logic nclk_in,
    output logic lclk_out,
    output logic ser_out,
    output logic [3:0] nib_out,
    output logic taken_out
);
    logic [3:0] ph;
    logic hold;
    logic launch;
    logic nclk_d;
    ////////////////////////////////////////////////////////////////
    // Free-running clock, data launched just after each rise
    always_ff @(posedge clk_in) begin
        launch <= 1'b0;
        nclk_d <= nclk_in;
        if (rst_in) begin
            ph <= 4'h0;
            lclk_out <= 1'b0;
            ser_out <= 1'b0;
            nib_out <= 4'h0;
            hold <= 1'b0;
            taken_out <= 1'b0;
        end else if (ph >= half_in - 4'h1) begin
            ph <= 4'h0;
            lclk_out <= ~lclk_out;
            if (!lclk_out) begin
                taken_out <= ser_out;
                hold <= oh_in;
                launch <= 1'b1;
            end
        end else begin
            ph <= ph + 4'h1;
        end
        // Held bit stays on the line for one more period
        if (launch && !hold) begin
            ser_out <= rnd_in[0];
        end
        // New nibble on every nibble clock rise
        if (nclk_in && !nclk_d) begin
            nib_out <= rnd_in[7:4];
        end
    end
endmodule

// ---- tb/etp_tx_payload_tb_top.sv ----
`timescale 1ns/1ps
module etp_tx_payload_tb_top;
    import etp_pkg::*;
    localparam logic SELS [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    localparam logic [1:0] TRSS [4] = '{TRS_LOCAL, TRS_LOOP, TRS_LOOP, 2'h3};
    localparam etp_mode_e MODES [4] = '{ETP_SERIAL, ETP_NIBBLE, ETP_IDLE, ETP_IDLE};
    logic clk;
    logic rst;
    logic nsel;
    logic lclk;
    logic ser;
    logic taken;
    logic fb, oh, nclk, nfb, noh;
    logic [3:0] nib;
    logic [3:0] half;
    logic [31:0] rnd;
    etp_apb_req_s req;
    etp_apb_rsp_s rsp;
    etp_payload_s pay;
    int fail_count;
    int tests_run;
    int cycles;
    ////////////////////////////////////////////////////////////////
    // Device and terminal, all pin clocks from one source
    etp_tx_payload dut (.MCLK_IN(clk), .RST_IN(rst), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
        .TX_REFERENCE_CLOCK_IN(lclk), .RECEIVE_LINE_CLOCK_IN(lclk), .RECOVERED_RECEIVE_CLOCK_IN(lclk),
        .SERIAL_PAYLOAD_IN(ser), .NIBBLE_PAYLOAD_IN(nib), .NIBBLE_SELECT_IN(nsel),
        .FRAME_BOUNDARY_OUT(fb), .OVERHEAD_INDICATOR_OUT(oh), .NIBBLE_CLOCK_OUT(nclk),
        .NIBBLE_FRAME_BOUNDARY_OUT(nfb), .NIBBLE_OVERHEAD_INDICATOR_OUT(noh), .PAYLOAD_OUT(pay));
    etp_term_model term (.clk_in(clk), .rst_in(rst), .half_in(half), .rnd_in(rnd), .oh_in(oh),
        .nclk_in(nclk), .lclk_out(lclk), .ser_out(ser), .nib_out(nib), .taken_out(taken));
    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected per-frame counts: cycles, boundary, overhead, oh rises, clk high, clk rises, valids, other-mode strobes
    function automatic int expect_of(input logic nm, input int k);
        int s[8];
        int p[8];
        s = '{4296 * 6, 6, 56 * 6, 6, 0, 0, 4296 - 56, 0};
        p = '{1074 * 16, 16, 14 * 16, 6, 1074 * 8, 1074, 1074 - 14, 0};
        return nm ? p[k] : s[k];
    endfunction
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 50) fail_count++;
    endtask
    task automatic set_mode(input logic sel, input logic [1:0] trs);
        logic [31:0] d;
        logic e;
        @(posedge clk);
        nsel <= sel;
        apb(1'b1, OPMODE_ADDR, {24'h0, OPMODE_RESET[7:2], trs}, d, e);
    endtask
    // Watch one full frame between two boundary rises
    task automatic run_frame(input logic nm);
        int c[8];
        int n;
        int gap;
        int ph;
        logic pb, po, pk, b, o;
        c = '{default: 0};
        n = 0;
        gap = 0;
        ph = 0;
        pb = 1'b1;
        po = 1'b1;
        pk = 1'b1;
        while (ph < 2 && n < 60000) begin
            @(posedge clk);
            #1;
            n++;
            b = nm ? nfb : fb;
            o = nm ? noh : oh;
            gap = (nclk && !pk) ? 0 : gap + 1;
            if (b && !pb) ph++;
            if (ph == 1) begin
                c[0]++;
                c[1] += b;
                c[2] += o;
                c[3] += (o && !po);
                c[4] += nclk;
                c[5] += (nclk && !pk);
                c[7] += nm ? (fb | oh) : (nclk | nfb | noh);
                if (pay.valid === 1'b1) begin
                    c[6]++;
                    check("nibble flag", {31'h0, nm}, {31'h0, pay.nibble});
                    if (nm) begin
                        check("nibble data", {28'h0, nib}, {28'h0, pay.data});
                        check("nibble take delay", 32'h1, {31'h0, gap >= 12 && gap < 16});
                    end else begin
                        check("serial bit", {31'h0, taken}, {31'h0, pay.data[0]});
                    end
                end
            end
            pb = b;
            po = o;
            pk = nclk;
        end
        check("frames seen", 32'h2, ph);
        for (int k = 0; k < 8; k++) begin
            check($sformatf("frame stat %0d", k), expect_of(nm, k), c[k]);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Clock, random source and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rnd <= lfsr(rnd);
        cycles <= cycles + 1;
        if (cycles == 99000) begin
            fail_count++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        logic e;
        logic [7:0] v;
        rst = 1'b1;
        req = '0;
        nsel = 1'b0;
        half = 4'd3;
        rnd = 32'h8213206e;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, OPMODE_ADDR, 32'h0, d, e);
        check("opmode reset", {24'h0, OPMODE_RESET}, d);
        apb(1'b0, 8'h0c, 32'h0, d, e);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, d);
        apb(1'b1, STATUS_ADDR, rnd, d, e);
        check("status write error", 32'h0, {31'h0, e});
        v = rnd[15:8];
        apb(1'b1, OPMODE_ADDR, {24'h0, v[7:2], 2'h2}, d, e);
        apb(1'b0, OPMODE_ADDR, 32'h0, d, e);
        check("opmode readback", {24'h0, v[7:2], 2'h2}, d);
        for (int i = 0; i < 4; i++) begin
            set_mode(SELS[i], TRSS[i]);
            repeat (10) @(posedge clk);
            apb(1'b0, STATUS_ADDR, 32'h0, d, e);
            check($sformatf("mode %0d", i), {30'h0, MODES[i]}, {30'h0, d[STAT_MODE_LSB +: 2]});
        end
        repeat (20) @(posedge clk);
        #1;
        check("idle strobes", 32'h0, {26'h0, fb, oh, nclk, nfb, noh, pay.valid});
        $display("Test registers done");
        set_mode(1'b0, TRS_LOCAL);
        run_frame(1'b0);
        $display("Test serial done");
        @(posedge clk);
        half <= 4'd2;
        set_mode(1'b1, TRS_LOOP);
        run_frame(1'b1);
        $display("Test nibble done");
        set_mode(1'b0, TRS_LOOP);
        repeat (20) @(posedge clk);
        #1;
        check("exit strobes", 32'h0, {26'h0, fb, oh, nclk, nfb, noh, pay.valid});
        $display("Test exit done");
        close_out();
    end
endmodule
